// file: rtl/cmtmr_pkg.sv
// Constants shared by the two-channel compare match timer.
package cmtmr_pkg;
    localparam int CHANNELS = 2;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 8;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_RUN       = 6'h00;
    localparam logic [5:0] IDX_CTRL0     = 6'h02;
    localparam logic [5:0] IDX_CNT0      = 6'h04;
    localparam logic [5:0] IDX_CONST0    = 6'h06;
    localparam logic [5:0] IDX_CTRL1     = 6'h08;
    localparam logic [5:0] IDX_CNT1      = 6'h0a;
    localparam logic [5:0] IDX_CONST1    = 6'h0c;
    localparam logic [5:0] IDX_IRQ_STAT  = 6'h0e;
    localparam logic [5:0] IDX_IRQ_MASK  = 6'h10;
    localparam logic [5:0] IDX_CH_STRIDE = 6'h06;

    // Control register fields.
    localparam int CTRL_FLAG_BIT   = 7;
    localparam int CTRL_IRQ_EN_BIT = 6;
    localparam int CTRL_SEL_HI     = 1;
    localparam int CTRL_SEL_LO     = 0;

    // Reset values.
    localparam logic [15:0] RST_CONST = 16'hffff;
    localparam logic [15:0] RST_CNT   = 16'h0000;
    localparam logic [1:0]  RST_SEL   = 2'h0;

    // Prescaler: divide by 8, 32, 128, 512 is 2**(3 + 2*sel).
    localparam int PRE_W     = 9;
    localparam int PRE_BASE  = 3;
    localparam int PRE_STEP  = 2;
    localparam int PRE_TAPS  = 4;
endpackage

// file: rtl/cmtmr_prescaler.sv
// Free-running divider that makes the four prescaled count enables.
`timescale 1ns/100ps
module cmtmr_prescaler (
    // Clock, reset and standby
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       standby,
    // Count enables, one cycle wide
    output logic [3:0]      tick
);
    logic [cmtmr_pkg::PRE_W-1:0] div;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div <= '0;
        end else if (standby) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    // Each tap pulses once when its low bits are all ones.
    for (genvar k = 0; k < cmtmr_pkg::PRE_TAPS; k++) begin : g_tap
        localparam int W = cmtmr_pkg::PRE_BASE + cmtmr_pkg::PRE_STEP * k;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                tick[k] <= 1'b0;
            end else if (standby) begin
                tick[k] <= 1'b0;
            end else begin
                tick[k] <= &div[W-1:0];
            end
        end
    end
endmodule // cmtmr_prescaler

// file: rtl/cmtmr_top.sv
// Two-channel 16-bit compare match timer with an Avalon-MM register slave.
// What this block does
// - A running channel counts up on each selected prescaled clock pulse.
// - On match the counter returns to zero, flag sets, counting continues.
// - A channel's request is high one cycle after its flag and enable are both one.
// - Each channel drives its own compare match interrupt request line.
// - Counter clock is the system clock divided by 8, 32, 128 or 512.
// - Match acts on the count pulse after counter equals the constant.
// - Flag clears by writing zero after reading one; writing one is ignored.
// - A match in the write's taking cycle clears the counter; write is lost.
// - A word write beats a coinciding increment; the increment is lost.
// - A byte write loads its byte; other byte keeps its old value.
// - Run register bit 0 runs channel 0 and bit 1 runs channel 1.
// - Select 00 is /8, 01 /32, 10 /128, 11 /512; /8 after reset.
// - Reset and standby set constants to all ones and clear all other timer state; standby keeps readdata.
// - Control bit 6 enables the channel's compare match interrupt.
`timescale 1ns/100ps
module cmtmr_top (
    // Clock, reset and standby
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        standby,
    // Avalon-MM slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Interrupts
    output logic [1:0]       match_irq,
    output logic             irq
);
    localparam int NCH = cmtmr_pkg::CHANNELS;

    logic [3:0]  tick;
    logic [1:0]  run_bit;
    logic [1:0]  match_flag;
    logic [1:0]  match_irq_enable;
    logic [1:0]  clk_sel [NCH];
    logic [15:0] match_counter [NCH];
    logic [15:0] match_constant [NCH];
    logic [1:0]  flag_armed;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [1:0]  match_evt;
    logic        taken;
    logic        wr_go;
    logic        rd_go;
    logic [5:0]  idx;
    logic        on_word;
    logic [31:0] next_readdata;
    logic        run_hit;
    logic        stat_hit;
    logic        mask_hit;
    logic [1:0]  next_irq_status;

    cmtmr_prescaler u_prescaler (
        .clk     (clk),
        .rst     (rst),
        .standby (standby),
        .tick    (tick)
    );

    // Every access is answered one cycle after it is first seen.
    assign taken   = (read || write) && !waitrequest;
    assign wr_go   = write && !waitrequest;
    assign rd_go   = read && !waitrequest;
    assign on_word = (address[1:0] == 2'h0);
    assign idx     = address[7:2];
    assign run_hit  = on_word && idx == cmtmr_pkg::IDX_RUN;
    assign stat_hit = on_word && idx == cmtmr_pkg::IDX_IRQ_STAT;
    assign mask_hit = on_word && idx == cmtmr_pkg::IDX_IRQ_MASK;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
        end
    end

    // Reads decode as one flat chain; unmapped or misaligned reads give zero.
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (!on_word) begin
            next_readdata = 32'h0000_0000;
        end else if (idx == cmtmr_pkg::IDX_RUN) begin
            next_readdata[1:0] = run_bit;
        end else if (idx == cmtmr_pkg::IDX_CTRL0) begin
            next_readdata[cmtmr_pkg::CTRL_FLAG_BIT]   = match_flag[0];
            next_readdata[cmtmr_pkg::CTRL_IRQ_EN_BIT] = match_irq_enable[0];
            next_readdata[1:0]                        = clk_sel[0];
        end else if (idx == cmtmr_pkg::IDX_CNT0) begin
            next_readdata[15:0] = match_counter[0];
        end else if (idx == cmtmr_pkg::IDX_CONST0) begin
            next_readdata[15:0] = match_constant[0];
        end else if (idx == cmtmr_pkg::IDX_CTRL1) begin
            next_readdata[cmtmr_pkg::CTRL_FLAG_BIT]   = match_flag[1];
            next_readdata[cmtmr_pkg::CTRL_IRQ_EN_BIT] = match_irq_enable[1];
            next_readdata[1:0]                        = clk_sel[1];
        end else if (idx == cmtmr_pkg::IDX_CNT1) begin
            next_readdata[15:0] = match_counter[1];
        end else if (idx == cmtmr_pkg::IDX_CONST1) begin
            next_readdata[15:0] = match_constant[1];
        end else if (idx == cmtmr_pkg::IDX_IRQ_STAT) begin
            next_readdata[1:0] = irq_status;
        end else if (idx == cmtmr_pkg::IDX_IRQ_MASK) begin
            next_readdata[1:0] = irq_mask;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_bit <= 2'h0;
        end else if (standby) begin
            run_bit <= 2'h0;
        end else if (wr_go && run_hit && byteenable[0]) begin
            run_bit <= writedata[1:0];
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        localparam logic [5:0] OFS = 6'(c) * cmtmr_pkg::IDX_CH_STRIDE;
        logic        ctrl_hit;
        logic        cnt_hit;
        logic        const_hit;
        logic        tick_sel;
        logic [15:0] written;
        logic        ctrl_wr;
        logic        flag_clr;

        assign ctrl_hit  = on_word && idx == cmtmr_pkg::IDX_CTRL0 + OFS;
        assign cnt_hit   = on_word && idx == cmtmr_pkg::IDX_CNT0 + OFS;
        assign const_hit = on_word && idx == cmtmr_pkg::IDX_CONST0 + OFS;
        assign ctrl_wr   = wr_go && ctrl_hit && byteenable[0];
        // Clearing needs an earlier read that saw the flag set.
        assign flag_clr  = ctrl_wr && !writedata[cmtmr_pkg::CTRL_FLAG_BIT]
                           && flag_armed[c];
        assign tick_sel  = tick[clk_sel[c]] && run_bit[c];
        // The match is seen on the pulse after equality, not on equality.
        assign match_evt[c] = tick_sel
            && match_counter[c] == match_constant[c];
        assign written = {byteenable[1] ? writedata[15:8]
                                        : match_counter[c][15:8],
                          byteenable[0] ? writedata[7:0]
                                        : match_counter[c][7:0]};

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                match_counter[c] <= cmtmr_pkg::RST_CNT;
            end else if (standby) begin
                match_counter[c] <= cmtmr_pkg::RST_CNT;
            end else if (match_evt[c]) begin
                match_counter[c] <= cmtmr_pkg::RST_CNT;
            end else if (wr_go && cnt_hit) begin
                match_counter[c] <= written;
            end else if (tick_sel) begin
                match_counter[c] <= match_counter[c] + 16'h0001;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                match_constant[c] <= cmtmr_pkg::RST_CONST;
            end else if (standby) begin
                match_constant[c] <= cmtmr_pkg::RST_CONST;
            end else if (wr_go && const_hit) begin
                if (byteenable[0]) begin
                    match_constant[c][7:0] <= writedata[7:0];
                end
                if (byteenable[1]) begin
                    match_constant[c][15:8] <= writedata[15:8];
                end
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                clk_sel[c] <= cmtmr_pkg::RST_SEL;
            end else if (standby) begin
                clk_sel[c] <= cmtmr_pkg::RST_SEL;
            end else if (ctrl_wr) begin
                clk_sel[c] <= writedata[cmtmr_pkg::CTRL_SEL_HI:
                                        cmtmr_pkg::CTRL_SEL_LO];
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                match_irq_enable[c] <= 1'b0;
            end else if (standby) begin
                match_irq_enable[c] <= 1'b0;
            end else if (ctrl_wr) begin
                match_irq_enable[c] <=
                    writedata[cmtmr_pkg::CTRL_IRQ_EN_BIT];
            end
        end

        // The match is tested first so that a clear landing on it loses.
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                match_flag[c] <= 1'b0;
            end else if (standby) begin
                match_flag[c] <= 1'b0;
            end else if (match_evt[c]) begin
                match_flag[c] <= 1'b1;
            end else if (flag_clr) begin
                match_flag[c] <= 1'b0;
            end
        end

        // A read that shows the flag set arms the clear-by-zero write.
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                flag_armed[c] <= 1'b0;
            end else if (standby) begin
                flag_armed[c] <= 1'b0;
            end else if (flag_clr && !match_evt[c]) begin
                flag_armed[c] <= 1'b0;
            end else if (rd_go && ctrl_hit && match_flag[c]
                    && !match_evt[c]) begin
                flag_armed[c] <= 1'b1;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                match_irq[c] <= 1'b0;
            end else begin
                match_irq[c] <= match_flag[c] && match_irq_enable[c]
                                && !standby;
            end
        end
    end

    // Sticky event copy for the summary interrupt; the event is merged in
    // after the clear, so a match in the clearing cycle is never lost.
    always_comb begin
        next_irq_status = irq_status;
        if (wr_go && stat_hit && byteenable[0]) begin
            next_irq_status = irq_status & ~writedata[1:0];
        end
        next_irq_status = next_irq_status | match_evt;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= 2'h0;
        end else if (standby) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask <= 2'h0;
        end else if (standby) begin
            irq_mask <= 2'h0;
        end else if (wr_go && mask_hit && byteenable[0]) begin
            irq_mask <= writedata[1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule // cmtmr_top

// file: bench/cmtmr_asserts.sv
// Port-level checks of the compare match timer.
`timescale 1ns/100ps
module cmtmr_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        standby,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [1:0]  match_irq,
    input wire logic        irq
);
    logic wr_done;
    assign wr_done = write && !waitrequest;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_ack; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("no answer");
    property p_one; !waitrequest |=> waitrequest; endproperty
    a_one: assert property (p_one) else $error("long answer");
    property p_idle; !read && !write && waitrequest |=> waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_rdhi; !waitrequest |-> readdata[31:16] == 16'h0000; endproperty
    a_rdhi: assert property (p_rdhi) else $error("upper data set");
    property p_rdst;
        !(read && waitrequest) && !standby |=> $stable(readdata);
    endproperty
    a_rdst: assert property (p_rdst) else $error("data moved");
    property p_stby; standby [*2] |=> match_irq == 2'b00 && !irq; endproperty
    a_stby: assert property (p_stby) else $error("irq in standby");
    property p_hold0;
        match_irq[0] && !wr_done && !$past(wr_done) && !standby
            |=> match_irq[0];
    endproperty
    a_hold0: assert property (p_hold0) else $error("irq0 dropped");
    property p_hold1;
        match_irq[1] && !wr_done && !$past(wr_done) && !standby
            |=> match_irq[1];
    endproperty
    a_hold1: assert property (p_hold1) else $error("irq1 dropped");
    property p_irqh;
        irq && !wr_done && !$past(wr_done) && !standby |=> irq;
    endproperty
    a_irqh: assert property (p_irqh) else $error("irq dropped");
    property p_fall0;
        $fell(match_irq[0]) |-> $past(wr_done, 2) || $past(standby);
    endproperty
    a_fall0: assert property (p_fall0) else $error("irq0 fell alone");
endmodule // cmtmr_asserts
bind cmtmr_top cmtmr_asserts u_chk (.clk(clk), .rst(rst), .standby(standby),
    .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .match_irq(match_irq), .irq(irq));

// file: bench/cmtmr_intc_model.sv
// Interrupt controller stand-in counting request edges per channel.
`timescale 1ns/100ps
module cmtmr_intc_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Requests from the timer
    input  wire logic [1:0] match_irq,
    // Requests taken per channel
    output logic [7:0]      taken0,
    output logic [7:0]      taken1
);
    logic [1:0] prev;
    // Lines are separate bits of match_irq, so each is counted apart.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev   <= 2'h0;
            taken0 <= 8'h00;
            taken1 <= 8'h00;
        end else begin
            prev   <= match_irq;
            taken0 <= taken0 + 8'(match_irq[0] && !prev[0]);
            taken1 <= taken1 + 8'(match_irq[1] && !prev[1]);
        end
    end
endmodule // cmtmr_intc_model

// file: bench/testbench.sv
// Self-checking bench for the two-channel compare match timer.
`timescale 1ns/100ps
module testbench;
    logic        clk, rst, standby, read, write, waitrequest, irq;
    logic [7:0]  address, taken0, taken1;
    logic [31:0] writedata, readdata, seed;
    logic [3:0]  byteenable;
    logic [1:0]  match_irq;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    cmtmr_top u_dut (.clk(clk), .rst(rst), .standby(standby),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .match_irq(match_irq), .irq(irq));
    cmtmr_intc_model u_intc (.clk(clk), .rst(rst), .match_irq(match_irq),
        .taken0(taken0), .taken1(taken1));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int div(input int s);
        return 8 << (2 * s);
    endfunction
    task automatic wrap_up();
        $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // A stuck slave is caught only by the global cycle ceiling.
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [15:0] d, input logic [1:0] be, output logic [15:0] q);
        address    <= a;
        writedata  <= {16'h0000, d};
        byteenable <= {2'b00, be};
        read       <= !wr;
        write      <= wr;
        @(posedge clk);
        while (waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = readdata[15:0];
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, 2'b11, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, 2'b11, q);
        chk(q, e);
    endtask
    task automatic chk_irq(input logic [15:0] e);
        repeat (2) @(posedge clk);
        chk({13'h0, match_irq, irq}, e);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        logic [15:0] q, c0, d;
        int          n;
        rst = 1'b1;
        standby = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
        seed = 32'h7f40;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            rdc(8'(8 * i), (i == 3 || i == 6) ? 16'hffff : 16'h0000);
        end
        wr(8'h08, 16'hffff);
        rdc(8'h08, 16'h0043);
        wr(8'hfc, 16'h1234);
        rdc(8'hfc, 16'h0000);
        wr(8'h00, 16'h0002);
        for (int s = 0; s < 4; s++) begin
            wr(8'h20, 16'(s));
            bus(1'b0, 8'h28, 16'h0000, 2'b11, c0);
            repeat (4 * div(s) - 3) @(posedge clk);
            bus(1'b0, 8'h28, 16'h0000, 2'b11, q);
            chk(q - c0, 16'h0004);
        end
        wr(8'h00, 16'h0000);
        bus(1'b0, 8'h28, 16'h0000, 2'b11, c0);
        repeat (40) @(posedge clk);
        rdc(8'h28, c0);
        d = 16'(2 + rnd() % 6);
        wr(8'h18, d);
        wr(8'h10, d);
        wr(8'h40, 16'h0001);
        wr(8'h08, 16'h0040);
        repeat (20) @(posedge clk);
        rdc(8'h08, 16'h0040);
        wr(8'h00, 16'h0001);
        n = 0;
        while (match_irq[0] !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk_irq(16'h0003);
        wr(8'h00, 16'h0000);
        bus(1'b0, 8'h10, 16'h0000, 2'b11, q);
        chk(16'(q < d), 16'h0001);
        chk({taken1, taken0}, 16'h0001);
        wr(8'h08, 16'h00c0);
        rdc(8'h08, 16'h00c0);
        wr(8'h08, 16'h0040);
        rdc(8'h08, 16'h0040);
        chk_irq(16'h0001);
        wr(8'h40, 16'h0000);
        chk_irq(16'h0000);
        wr(8'h40, 16'h0001);
        chk_irq(16'h0001);
        wr(8'h38, 16'h0001);
        chk_irq(16'h0000);
        standby <= 1'b1;
        repeat (2) @(posedge clk);
        standby <= 1'b0;
        @(posedge clk);
        rdc(8'h18, 16'hffff);
        rdc(8'h08, 16'h0000);
        d = 16'(rnd());
        wr(8'h28, d);
        q = 16'(rnd());
        bus(1'b1, 8'h28, q, 2'b01, c0);
        rdc(8'h28, {d[15:8], q[7:0]});
        wrap_up();
    end
endmodule // testbench
